// File: design/refresh_map.svh
// Address, field, reset and timing constants of the display refresh interface.
`ifndef REFRESH_MAP_SVH
`define REFRESH_MAP_SVH

// host write locations, full memory address and short port number
`define CHAR_ADDR        16'hbf04
`define DIGIT_ADDR       16'hbf05
`define CHAR_PORT        8'h04
`define DIGIT_PORT       8'h05

// field widths and display size
`define CHAR_W           6
`define DIGIT_W          5
`define NUM_DIGITS       16

// digit-select codes and latch reset values
`define DIGIT_LEFT       5'h00
`define DIGIT_RIGHT      5'h0f
`define DIGIT_BLANK      5'h1f
`define CHAR_RESET       6'h00

// status word bit positions
`define STAT_OUT_BIT     4
`define STAT_MEMWN_BIT   1

// timing
`define CLK_HZ           200000000
`define REFRESH_HZ       1600
`define TICK_W           20
`define WAIT_CYCLES      2'd1

`endif

// File: design/refresh_pkg.sv
// Types shared by the display refresh interface modules.
package refresh_pkg;
  typedef logic [5:0]  char_code_t;
  typedef logic [4:0]  digit_word_t;
  typedef logic [15:0] digit_enable_t;

  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_STALL = 2'b01,
    WR_ARMED = 2'b10
  } wr_state_t;
endpackage

// File: design/refresh_if.sv
// Link between the refresh interface core and its digit decoder.
`timescale 1ns/1ps
interface refresh_if;
  import refresh_pkg::*;
  digit_word_t   digitWord;
  digit_enable_t digitEnable;
  logic          ce;

  modport drv (output digitWord, output ce, input digitEnable);
  modport dec (input digitWord, input ce, output digitEnable);
endinterface

// File: design/digit_decoder.sv
// Registered decode of the digit-select word into one digit enable per position.
`timescale 1ns/1ps
`include "refresh_map.svh"
module digit_decoder
  import refresh_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // select word in, enables out
  refresh_if.dec   link
);

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_DIGITS; gi++) begin : g_digit
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          link.digitEnable[gi] <= 1'b0;
        end else if (link.ce) begin
          link.digitEnable[gi] <= (link.digitWord == 5'(gi));
        end
      end
    end
  endgenerate

  // codes 10..1f match no position, so 1f blanks all
  chk_onehot_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
    link.ce && (link.digitWord <= `DIGIT_RIGHT) |=>
      link.digitEnable == (16'h0001 << $past(link.digitWord)))
    else $error("digit enable not one-hot on select code");

  chk_blank_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    link.ce && (link.digitWord == `DIGIT_BLANK) |=> link.digitEnable == 16'h0000)
    else $error("blank code left a digit lit");

endmodule // digit_decoder

// File: design/display_refresh.sv
// Interrupt-driven refresh interface for a multiplexed 16-position display.
`timescale 1ns/1ps
`include "refresh_map.svh"
module display_refresh
  import refresh_pkg::*;
#(
  parameter int REFRESH_HZ = `REFRESH_HZ
) (
  // clock, reset, enable
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  // host bus pins
  input  wire logic [15:0]   hostAddr,
  input  wire logic [7:0]    hostData,
  input  wire logic          phi1,
  input  wire logic          phi2,
  input  wire logic          syncStatus,
  input  wire logic          writeStrobeN,
  input  wire logic          hostHasStatus,
  input  wire logic          ioSpaceSel,
  // host handshake
  output logic               refreshReq,
  output logic               hostReady,
  // display drivers
  output logic [5:0]         charCode,
  output logic [15:0]        digitEnable
);

  localparam int TICK_DIV = `CLK_HZ / REFRESH_HZ;
  localparam int PINS     = 30;
  // strobe idles high, so its filter starts high to avoid a false edge
  localparam logic [PINS-1:0] PIN_IDLE = {16'h0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1,
                                          1'b0, 1'b0};

  logic [PINS-1:0]     pinRaw;
  logic [PINS-1:0]     pinS1;
  logic [PINS-1:0]     pinS2;
  logic [PINS-1:0]     pinS3;
  logic [PINS-1:0]     pinFilt;
  logic [15:0]         addrF;
  logic [7:0]          dataF;
  logic                phi1F;
  logic                phi2F;
  logic                syncF;
  logic                wrF;
  logic                statusF;
  logic                ioSelF;
  logic                phi1Q;
  logic                phi2Q;
  logic                wrQ;
  logic                phi1Rise;
  logic                phi2Fall;
  logic                wrRise;
  logic [7:0]          status_r;
  logic                memWrite;
  logic                ioWrite;
  logic                spaceOk;
  logic                charHit;
  logic                digitHit;
  logic                charWrite;
  logic                digitWrite;
  char_code_t          char_r;
  digit_word_t         digitSel_r;
  logic [`TICK_W-1:0]  tickCnt_r;
  logic                tick;
  logic                req_r;
  wr_state_t           wrState_r;
  wr_state_t           wrState_nxt;
  logic [1:0]          waitCnt_r;

  refresh_if link ();

  assign pinRaw = {hostAddr, hostData, phi1, phi2, syncStatus, writeStrobeN,
                   hostHasStatus, ioSpaceSel};
  assign {addrF, dataF, phi1F, phi2F, syncF, wrF, statusF, ioSelF} = pinFilt;

  // pins are asynchronous: three stages, accept once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pinS1[gi]   <= PIN_IDLE[gi];
          pinS2[gi]   <= PIN_IDLE[gi];
          pinS3[gi]   <= PIN_IDLE[gi];
          pinFilt[gi] <= PIN_IDLE[gi];
        end else if (ce) begin
          pinS1[gi] <= pinRaw[gi];
          pinS2[gi] <= pinS1[gi];
          pinS3[gi] <= pinS2[gi];
          if (pinS2[gi] == pinS3[gi]) begin
            pinFilt[gi] <= pinS3[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phi1Q <= 1'b0;
      phi2Q <= 1'b0;
      wrQ   <= 1'b1;
    end else if (ce) begin
      phi1Q <= phi1F;
      phi2Q <= phi2F;
      wrQ   <= wrF;
    end
  end

  assign phi1Rise = phi1F & ~phi1Q;
  assign phi2Fall = ~phi2F & phi2Q;
  assign wrRise   = wrF & ~wrQ;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 8'h00;
    end else if (ce && phi1Rise && syncF) begin
      status_r <= dataF;
    end
  end

  // memory or I/O write from status
  assign memWrite = ~status_r[`STAT_MEMWN_BIT];
  assign ioWrite  = status_r[`STAT_OUT_BIT];
  assign spaceOk  = ~statusF | (ioSelF ? ioWrite : memWrite);

  assign charHit  = ioSelF ? (addrF[7:0] == `CHAR_PORT)  : (addrF == `CHAR_ADDR);
  assign digitHit = ioSelF ? (addrF[7:0] == `DIGIT_PORT) : (addrF == `DIGIT_ADDR);

  // data taken at the trailing strobe edge, where the host still holds it
  assign charWrite  = ce & wrRise & charHit & spaceOk;
  assign digitWrite = ce & wrRise & digitHit & spaceOk;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      char_r <= `CHAR_RESET;
    end else if (charWrite) begin
      char_r <= dataF[5:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      digitSel_r <= `DIGIT_BLANK;
    end else if (digitWrite) begin
      digitSel_r <= dataF[4:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_r <= '0;
    end else if (ce) begin
      if (tick) begin
        tickCnt_r <= '0;
      end else begin
        tickCnt_r <= tickCnt_r + 1'b1;
      end
    end
  end

  assign tick = (tickCnt_r == `TICK_W'(TICK_DIV - 1));

  // request held until the host's first digit write; a new tick wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_r <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        req_r <= 1'b1;
      end else if (digitWrite) begin
        req_r <= 1'b0;
      end
    end
  end

  // wait insertion, only for hosts that send status
  // re-armed only by the next status word: a lingering address must not stall again
  always_comb begin
    wrState_nxt = wrState_r;
    case (wrState_r)
      WR_IDLE: begin
        if (statusF && (charHit || digitHit) && spaceOk && wrF) begin
          wrState_nxt = (`WAIT_CYCLES != 2'd0) ? WR_STALL : WR_ARMED;
        end else if (!wrF) begin
          wrState_nxt = WR_ARMED;
        end
      end
      WR_STALL: begin
        if (phi2Fall && (waitCnt_r == `WAIT_CYCLES - 2'd1)) begin
          wrState_nxt = WR_ARMED;
        end
      end
      WR_ARMED: begin
        if (phi1Rise && syncF) begin
          wrState_nxt = WR_IDLE;
        end
      end
      default: wrState_nxt = WR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrState_r <= WR_IDLE;
    end else if (ce) begin
      wrState_r <= wrState_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt_r <= 2'd0;
    end else if (ce) begin
      if (wrState_r != WR_STALL) begin
        waitCnt_r <= 2'd0;
      end else if (phi2Fall) begin
        waitCnt_r <= waitCnt_r + 2'd1;
      end
    end
  end

  assign link.digitWord = digitSel_r;
  assign link.ce        = ce;

  digit_decoder u_dec (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .link    (link)
  );

  assign refreshReq  = req_r;
  // ready low as soon as the stall state is entered, ahead of phase-two fall
  assign hostReady   = (wrState_r != WR_STALL);
  assign charCode    = char_r;
  assign digitEnable = link.digitEnable;

  chk_tick_raises: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && tick |=> refreshReq)
    else $error("refresh request not raised on divider wrap");

  chk_tick_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    tickCnt_r <= `TICK_W'(TICK_DIV - 1))
    else $error("refresh divider ran past its period");

  chk_req_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    digitWrite && !tick |=> !refreshReq)
    else $error("refresh request not dropped by digit write");

  chk_char_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    charWrite |=> charCode == $past(dataF[5:0]))
    else $error("character latch missed a write");

  chk_digit_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !digitWrite |=> $stable(digitSel_r))
    else $error("digit latch changed without a write");

  chk_digit_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    digitWrite |-> (ioSelF ? addrF[7:0] == `DIGIT_PORT : addrF == `DIGIT_ADDR)
      ##1 digitSel_r == $past(dataF[4:0]))
    else $error("digit write at wrong location or not latched");

  chk_status_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && phi1Rise && syncF |=> status_r == $past(dataF))
    else $error("status word not latched on phase-one rise");

  chk_reset_blank: assert property (@(posedge sys_clk)
    $rose(rstn) |-> digitSel_r == `DIGIT_BLANK ##1 digitEnable == 16'h0000)
    else $error("digit lit out of reset");

  chk_ready_release: assert property (@(posedge sys_clk) disable iff (!rstn)
    ce && (wrState_r == WR_STALL) && phi2Fall && (waitCnt_r == `WAIT_CYCLES - 2'd1)
      |=> hostReady)
    else $error("ready held low past the wait count");

endmodule // display_refresh

// File: tb/host_model.sv
// Host bus model: one write cycle per call on the refresh interface pins.
`timescale 1ns/1ps
module host_model (
  // clock and handshake from the device
  input  wire logic        sys_clk,
  input  wire logic        hostReady,
  // host bus pins
  output logic [15:0]      hostAddr,
  output logic [7:0]       hostData,
  output logic             phi1,
  output logic             phi2,
  output logic             syncStatus,
  output logic             writeStrobeN
);
  logic readyLowSeen;

  initial begin
    hostAddr     = 16'hffff;
    hostData     = 8'hff;
    phi1         = 1'b0;
    phi2         = 1'b0;
    syncStatus   = 1'b0;
    writeStrobeN = 1'b1;
    readyLowSeen = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // status word on the data pins while sync is high, taken at phi1 rise
  task automatic write_loc(input logic [15:0] addr, input logic [7:0] status,
                           input logic [7:0] data);
    int i;
    @(negedge sys_clk);
    hostAddr   = addr;
    hostData   = status;
    syncStatus = 1'b1;
    hold(4);
    phi1 = 1'b1;
    hold(6);
    phi1         = 1'b0;
    syncStatus   = 1'b0;
    hostData     = data;
    writeStrobeN = 1'b0;
    hold(6);
    readyLowSeen = (hostReady === 1'b0);
    phi2         = 1'b1;
    hold(4);
    phi2 = 1'b0;
    // wait states end after phi2 fall; strobe held until ready seen high
    for (i = 0; i < 20 && hostReady !== 1'b1; i++) begin
      hold(1);
    end
    hold(2);
    writeStrobeN = 1'b1;
    hold(8);
    // released pins show the inverse, never the old value
    hostAddr = ~addr;
    hostData = ~data;
  endtask
endmodule // host_model

// File: tb/test_interrupt_driven_display_refresh.sv
// Self-checking bench for the display refresh interface.
`timescale 1ns/1ps
`include "refresh_map.svh"
module test_interrupt_driven_display_refresh;
  import refresh_pkg::*;
  // short count keeps the run brief: 200 cycles per request
  localparam int RATE_HZ  = 1000000;
  localparam int TICK_DIV = `CLK_HZ / RATE_HZ;

  logic          sys_clk, rstn, ce, hostHasStatus, ioSpaceSel;
  logic [15:0]   hostAddr;
  logic [7:0]    hostData;
  logic          phi1, phi2, syncStatus, writeStrobeN;
  logic          refreshReq, hostReady;
  char_code_t    charCode;
  digit_enable_t digitEnable;
  int            badCount, totalChecks, n, i;

  display_refresh #(.REFRESH_HZ(RATE_HZ)) display_refresh_inst (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hostAddr(hostAddr), .hostData(hostData),
    .phi1(phi1), .phi2(phi2), .syncStatus(syncStatus), .writeStrobeN(writeStrobeN),
    .hostHasStatus(hostHasStatus), .ioSpaceSel(ioSpaceSel), .refreshReq(refreshReq),
    .hostReady(hostReady), .charCode(charCode), .digitEnable(digitEnable));

  host_model host_model_inst (
    .sys_clk(sys_clk), .hostReady(hostReady), .hostAddr(hostAddr), .hostData(hostData),
    .phi1(phi1), .phi2(phi2), .syncStatus(syncStatus), .writeStrobeN(writeStrobeN));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_req(output int cnt);
    cnt = 0;
    while (refreshReq !== 1'b1 && cnt < 2 * TICK_DIV) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    reportAndStop();
  end

  initial begin
    rstn          = 1'b0;
    ce            = 1'b1;
    hostHasStatus = 1'b0;
    ioSpaceSel    = 1'b0;
    badCount      = 0;
    totalChecks   = 0;
    repeat (3) @(negedge sys_clk);
    check("reset digitEnable", 16'h0000, digitEnable);
    check("reset charCode", 16'h0000, {10'h000, charCode});
    check("reset refreshReq", 16'h0000, {15'h0, refreshReq});
    rstn = 1'b1;
    wait_req(n);
    // margin covers the sync of reset release
    check("first tick", 16'h0001, {15'h0, n >= TICK_DIV - 3 && n <= TICK_DIV + 3});
    // host refresh loop: 16 positions, then wrap to the first
    for (i = 0; i <= 16; i++) begin
      if (i > 0) begin
        wait_req(n);
        check("tick spacing", 16'h0001, {15'h0, n < TICK_DIV});
      end
      check("refreshReq", 16'h0001, {15'h0, refreshReq});
      // blank digits first, then load the character, then light
      host_model_inst.write_loc(`DIGIT_ADDR, 8'h00, {3'b111, `DIGIT_BLANK});
      check("blank", 16'h0000, digitEnable);
      check("req cleared", 16'h0000, {15'h0, refreshReq});
      // upper data bits set on purpose; only six are kept
      host_model_inst.write_loc(`CHAR_ADDR, 8'h00, 8'hc0 | 8'(i));
      check("charCode", 16'(i % 64), {10'h000, charCode});
      // digit counter wraps after the last position
      host_model_inst.write_loc(`DIGIT_ADDR, 8'h00, 8'he0 | 8'(i % 16));
      check("digitEnable", 16'h0001 << (i % 16), digitEnable);
      check("char held", 16'(i % 64), {10'h000, charCode});
    end
    host_model_inst.write_loc(16'hbf06, 8'h00, 8'h05);
    check("unmapped write", 16'h0001, digitEnable);
    host_model_inst.write_loc(`DIGIT_ADDR, 8'h00, 8'h13);
    check("code 13 blanks", 16'h0000, digitEnable);
    // status words and wait states, I/O space first
    hostHasStatus = 1'b1;
    ioSpaceSel    = 1'b1;
    host_model_inst.write_loc({8'h12, `DIGIT_PORT}, 8'h10, 8'h07);
    check("io digit write", 16'h0080, digitEnable);
    check("wait inserted", 16'h0001, {15'h0, host_model_inst.readyLowSeen});
    check("ready after wait", 16'h0001, {15'h0, hostReady});
    host_model_inst.write_loc({8'h12, `DIGIT_PORT}, 8'h00, 8'h02);
    check("io wrong status", 16'h0080, digitEnable);
    ioSpaceSel = 1'b0;
    host_model_inst.write_loc(`CHAR_ADDR, 8'h02, 8'h2a);
    check("mem wrong status", 16'h0010, {10'h000, charCode});
    host_model_inst.write_loc(`CHAR_ADDR, 8'h00, 8'h2a);
    check("mem status write", 16'h002a, {10'h000, charCode});
    // frozen enable: a whole write cycle on the pins must leave the latches alone
    ce = 1'b0;
    host_model_inst.write_loc(`DIGIT_ADDR, 8'h00, 8'h03);
    check("ce low write", 16'h0080, digitEnable);
    ce = 1'b1;
    // second reset in mid-run
    rstn = 1'b0;
    @(negedge sys_clk);
    check("rereset digits", 16'h0000, digitEnable);
    check("rereset charCode", 16'h0000, {10'h000, charCode});
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("release digits", 16'h0000, digitEnable);
    check("release refreshReq", 16'h0000, {15'h0, refreshReq});
    reportAndStop();
  end
endmodule // test_interrupt_driven_display_refresh
